// *** common/tcdt_regs.vh ***
`ifndef TCDT_REGS_VH
`define TCDT_REGS_VH

// register indices; byte address is four times the index
`define TCDT_IDX_TEMP_TL      8'h60
`define TCDT_IDX_TEMP_TL_SUM  8'h61
`define TCDT_IDX_TEMP_TR      8'h62
`define TCDT_IDX_TEMP_TR_SUM  8'h63
`define TCDT_IDX_TEMP_BL      8'h64
`define TCDT_IDX_TEMP_BL_SUM  8'h65
`define TCDT_IDX_TEMP_BR      8'h66
`define TCDT_IDX_TEMP_BR_SUM  8'h67
`define TCDT_IDX_FINE_HI      8'h71
`define TCDT_IDX_FINE_LO      8'h72
`define TCDT_IDX_COARSE       8'h73
`define TCDT_IDX_MODE_CTRL    8'h7D
`define TCDT_IDX_CLK_CTRL     8'h80
`define TCDT_IDX_MOD_DIV      8'h85
`define TCDT_IDX_DLY_EN       8'hAE

// reset values
`define TCDT_RST_FINE         8'h00
`define TCDT_RST_COARSE       8'h00
`define TCDT_RST_MODE_CTRL    8'h04
`define TCDT_RST_CLK_CTRL     8'h3F
`define TCDT_RST_MOD_DIV      8'h01
`define TCDT_RST_DLY_EN       8'h00
`define TCDT_RST_PLL_EN       1'b1
`define TCDT_RST_DIV_FIELD    5'h01

// field positions and limits
`define TCDT_BIT_PLL_EN       2
`define TCDT_BIT_MOD_SRC      6
`define TCDT_BIT_DLY_EN       2
`define TCDT_DIV_W            5
`define TCDT_FINE_W           10
`define TCDT_COARSE_W         6
`define TCDT_FINE_MAX         10'h31F
`define TCDT_COARSE_MAX       6'h31
`define TCDT_SUM_READS        2'h3
`define TCDT_LED_QUARTER      2

`endif

// *** src/tcdt_temp_acc.v ***
`timescale 1ns/1ps
`default_nettype none
module tcdt_temp_acc (
  input  wire       i_sys_clk,
  input  wire       i_sys_rst,
  input  wire       i_row_strobe,
  input  wire [7:0] i_reading,
  output reg  [7:0] o_last,
  output reg  [7:0] o_sum
);
`include "tcdt_regs.vh"

  reg [1:0] cnt_q;
  reg [9:0] acc_q;
  wire [9:0] acc_d = acc_q + {2'h0, i_reading};

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt_q  <= 2'h0;
      acc_q  <= 10'h000;
      o_last <= 8'h00;
      o_sum  <= 8'h00;
    end else if (i_row_strobe) begin
      o_last <= i_reading;
      cnt_q  <= cnt_q + 2'h1;
      if (cnt_q == `TCDT_SUM_READS) begin
        o_sum <= acc_d[7:0];
        acc_q <= 10'h000;
      end else begin
        acc_q <= acc_d;
      end
    end
  end
endmodule // tcdt_temp_acc
`default_nettype wire

// *** src/tcdt_mod_div.v ***
`timescale 1ns/1ps
`default_nettype none
module tcdt_mod_div (
  input  wire       i_sys_clk,
  input  wire       i_sys_rst,
  input  wire       i_src_tick,
  input  wire [4:0] i_div,
  output reg        o_tick
);

  reg [4:0] cnt_q;

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt_q  <= 5'h00;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (i_src_tick) begin
        // compare with >= so a smaller divider written mid-count recovers
        if (cnt_q >= i_div) begin
          cnt_q  <= 5'h00;
          o_tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end
endmodule // tcdt_mod_div
`default_nettype wire

// *** src/tcdt_top.v ***
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tcdt_top (
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg         o_hreadyout,
  output reg  [31:0] o_hrdata,
  output reg         o_hresp,
  input  wire        i_row_strobe,
  input  wire [7:0]  i_temp_tl,
  input  wire [7:0]  i_temp_tr,
  input  wire [7:0]  i_temp_bl,
  input  wire [7:0]  i_temp_br,
  input  wire        i_ext_modulation_clock_in,
  output reg  [9:0]  o_led_fine_delay,
  output reg  [5:0]  o_led_coarse_delay,
  output reg         o_pll_enable,
  output reg         o_mod_src_ext,
  output wire        o_mod_clk_en,
  output reg         o_led_mod
);
`include "tcdt_regs.vh"

  // bus decode: only the low 10 address bits are mapped
  function mapped;
    input [31:0] addr;
    begin
      mapped = (addr[31:10] == 22'h000000);
    end
  endfunction

  function [9:0] clamp_fine;
    input [7:0] hi;
    input [7:0] lo;
    begin
      if (hi[7:2] != 6'h00 || {hi[1:0], lo} > `TCDT_FINE_MAX)
        clamp_fine = `TCDT_FINE_MAX;
      else
        clamp_fine = {hi[1:0], lo};
    end
  endfunction

  // one decoder serves every write strobe
  function wr_hit;
    input       act;
    input [7:0] idx;
    input [7:0] want;
    begin
      wr_hit = act & (idx == want);
    end
  endfunction

  function [5:0] clamp_coarse;
    input [7:0] v;
    begin
      if (v > {2'h0, `TCDT_COARSE_MAX})
        clamp_coarse = `TCDT_COARSE_MAX;
      else
        clamp_coarse = v[5:0];
    end
  endfunction

  // software registers
  reg [7:0] fine_hi_q;
  reg [7:0] fine_lo_q;
  reg [7:0] coarse_q;
  reg       pll_en_q;
  reg       mod_src_q;
  reg [4:0] mod_div_q;
  reg       dly_en_q;

  // bus pipeline
  reg       dp_act_q;
  reg       dp_wr_q;
  reg       dp_map_q;
  reg [7:0] dp_idx_q;

  // temperature results, byte 0 top left .. byte 3 bottom right
  wire [31:0] temp_last;
  wire [31:0] temp_sum;
  wire [7:0]  last_tl;
  wire [7:0]  last_tr;
  wire [7:0]  last_bl;
  wire [7:0]  last_br;
  wire [7:0]  sum_tl;
  wire [7:0]  sum_tr;
  wire [7:0]  sum_bl;
  wire [7:0]  sum_br;

  assign temp_last = {last_br, last_bl, last_tr, last_tl};
  assign temp_sum  = {sum_br, sum_bl, sum_tr, sum_tl};

  tcdt_temp_acc u_acc_tl (
    .i_sys_clk    (i_sys_clk),
    .i_sys_rst    (i_sys_rst),
    .i_row_strobe (i_row_strobe),
    .i_reading    (i_temp_tl),
    .o_last       (last_tl),
    .o_sum        (sum_tl)
  );

  tcdt_temp_acc u_acc_tr (
    .i_sys_clk    (i_sys_clk),
    .i_sys_rst    (i_sys_rst),
    .i_row_strobe (i_row_strobe),
    .i_reading    (i_temp_tr),
    .o_last       (last_tr),
    .o_sum        (sum_tr)
  );

  tcdt_temp_acc u_acc_bl (
    .i_sys_clk    (i_sys_clk),
    .i_sys_rst    (i_sys_rst),
    .i_row_strobe (i_row_strobe),
    .i_reading    (i_temp_bl),
    .o_last       (last_bl),
    .o_sum        (sum_bl)
  );

  tcdt_temp_acc u_acc_br (
    .i_sys_clk    (i_sys_clk),
    .i_sys_rst    (i_sys_rst),
    .i_row_strobe (i_row_strobe),
    .i_reading    (i_temp_br),
    .o_last       (last_br),
    .o_sum        (sum_br)
  );

  // address phase taken when selected, active and bus ready
  wire addr_take = i_hsel & i_htrans[1] & i_hready & o_hreadyout;
  wire wr_now    = dp_act_q & dp_wr_q & dp_map_q;

  wire wr_fine_hi = wr_hit(wr_now, dp_idx_q, `TCDT_IDX_FINE_HI);
  wire wr_fine_lo = wr_hit(wr_now, dp_idx_q, `TCDT_IDX_FINE_LO);
  wire wr_coarse  = wr_hit(wr_now, dp_idx_q, `TCDT_IDX_COARSE);
  wire wr_mode    = wr_hit(wr_now, dp_idx_q, `TCDT_IDX_MODE_CTRL);
  wire wr_clk     = wr_hit(wr_now, dp_idx_q, `TCDT_IDX_CLK_CTRL);
  wire wr_div     = wr_hit(wr_now, dp_idx_q, `TCDT_IDX_MOD_DIV);
  wire wr_dly     = wr_hit(wr_now, dp_idx_q, `TCDT_IDX_DLY_EN);

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      dp_act_q    <= 1'b0;
      dp_wr_q     <= 1'b0;
      dp_map_q    <= 1'b0;
      dp_idx_q    <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hresp <= 1'b0;
      if (addr_take) begin
        dp_act_q    <= 1'b1;
        dp_wr_q     <= i_hwrite;
        dp_map_q    <= mapped(i_haddr);
        dp_idx_q    <= i_haddr[9:2];
        // one wait state keeps reads coherent with the previous write
        o_hreadyout <= 1'b0;
      end else begin
        dp_act_q    <= 1'b0;
        o_hreadyout <= 1'b1;
      end
    end
  end

  // read data, registered at the end of the wait state
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (dp_idx_q)
      `TCDT_IDX_TEMP_TL:     rd_byte = temp_last[7:0];
      `TCDT_IDX_TEMP_TR:     rd_byte = temp_last[15:8];
      `TCDT_IDX_TEMP_BL:     rd_byte = temp_last[23:16];
      `TCDT_IDX_TEMP_BR:     rd_byte = temp_last[31:24];
      `TCDT_IDX_TEMP_TL_SUM: rd_byte = temp_sum[7:0];
      `TCDT_IDX_TEMP_TR_SUM: rd_byte = temp_sum[15:8];
      `TCDT_IDX_TEMP_BL_SUM: rd_byte = temp_sum[23:16];
      `TCDT_IDX_TEMP_BR_SUM: rd_byte = temp_sum[31:24];
      `TCDT_IDX_FINE_HI:     rd_byte = fine_hi_q;
      `TCDT_IDX_FINE_LO:     rd_byte = fine_lo_q;
      `TCDT_IDX_COARSE:      rd_byte = coarse_q;
      `TCDT_IDX_MODE_CTRL:   rd_byte = {5'h00, pll_en_q, 2'h0};
      `TCDT_IDX_CLK_CTRL:    rd_byte = {1'b0, mod_src_q, 6'h3F};
      `TCDT_IDX_MOD_DIV:     rd_byte = {3'h0, mod_div_q};
      `TCDT_IDX_DLY_EN:      rd_byte = {5'h00, dly_en_q, 2'h0};
      default:               rd_byte = 8'h00;
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h00000000;
    end else if (dp_act_q & ~dp_wr_q) begin
      o_hrdata <= dp_map_q ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // register writes in the data phase
  // fine count halves
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      fine_hi_q <= `TCDT_RST_FINE;
      fine_lo_q <= `TCDT_RST_FINE;
    end else begin
      if (wr_fine_hi)
        fine_hi_q <= i_hwdata[7:0];
      if (wr_fine_lo)
        fine_lo_q <= i_hwdata[7:0];
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst)
      coarse_q <= `TCDT_RST_COARSE;
    else if (wr_coarse)
      coarse_q <= i_hwdata[7:0];
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst)
      pll_en_q <= `TCDT_RST_PLL_EN;
    else if (wr_mode)
      pll_en_q <= i_hwdata[`TCDT_BIT_PLL_EN];
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst)
      mod_src_q <= 1'b0;
    else if (wr_clk)
      mod_src_q <= i_hwdata[`TCDT_BIT_MOD_SRC];
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst)
      mod_div_q <= `TCDT_RST_DIV_FIELD;
    else if (wr_div)
      mod_div_q <= i_hwdata[`TCDT_DIV_W-1:0];
  end

  // delay enable bit
  // only bit 2 is stored; the rest of that register lies outside this block
  always @(posedge i_sys_clk) begin
    if (i_sys_rst)
      dly_en_q <= 1'b0;
    else if (wr_dly)
      dly_en_q <= i_hwdata[`TCDT_BIT_DLY_EN];
  end

  // delay, PLL enable and modulation source outputs
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_led_fine_delay   <= 10'h000;
      o_led_coarse_delay <= 6'h00;
      o_pll_enable       <= 1'b1;
      o_mod_src_ext      <= 1'b0;
    end else begin
      o_led_fine_delay   <= dly_en_q ? clamp_fine(fine_hi_q, fine_lo_q)
                                     : 10'h000;
      o_led_coarse_delay <= dly_en_q ? clamp_coarse(coarse_q) : 6'h00;
      o_pll_enable       <= pll_en_q;
      o_mod_src_ext      <= mod_src_q;
    end
  end

  // external modulation clock: pin, so two flops before the edge detect
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_s3_q;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= i_ext_modulation_clock_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  wire ext_rise = ext_s2_q & ~ext_s3_q;

  // internal source: each system clock stands for one PLL clock,
  // and it stops while the PLL is disabled
  wire div_tick;
  tcdt_mod_div u_div (
    .i_sys_clk  (i_sys_clk),
    .i_sys_rst  (i_sys_rst),
    .i_src_tick (pll_en_q & ~mod_src_q),
    .i_div      (mod_div_q),
    .o_tick     (div_tick)
  );

  reg mod_tick_q;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst)
      mod_tick_q <= 1'b0;
    else
      mod_tick_q <= mod_src_q ? ext_rise : div_tick;
  end
  assign o_mod_clk_en = mod_tick_q;

  reg [1:0] quarter_q;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      quarter_q <= 2'h0;
      o_led_mod <= 1'b0;
    end else if (mod_tick_q) begin
      quarter_q <= quarter_q + 2'h1;
      o_led_mod <= quarter_q[0] ? ~quarter_q[1] : quarter_q[1];
    end
  end

endmodule // tcdt_top
`default_nettype wire

// *** verification/tcdt_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcdt_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hresp,
  input wire logic [9:0]  o_led_fine_delay,
  input wire logic [5:0]  o_led_coarse_delay,
  input wire logic        o_pll_enable,
  input wire logic        o_mod_src_ext,
  input wire logic        o_mod_clk_en
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic taken;
  assign taken = i_hsel && i_htrans[1] && i_hready && o_hreadyout;
  property p_okay; !o_hresp; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_wait; taken |=> !o_hreadyout ##1 o_hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_hold; $past(o_hreadyout) |-> $stable(o_hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rd_hi; o_hrdata[31:8] == 24'h000000; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_fine_max; o_led_fine_delay <= 10'h31F; endproperty
  a_fine_max: assert property (p_fine_max) else $error("fine high");
  property p_coarse_max; o_led_coarse_delay <= 6'h31; endproperty
  a_coarse_max: assert property (p_coarse_max) else $error("coarse");
  property p_rst_out; $fell(i_sys_rst) |-> o_pll_enable && !o_mod_src_ext;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset out");
  property p_dly_off;
    $fell(i_sys_rst) |-> o_led_fine_delay == 10'h000 &&
      o_led_coarse_delay == 6'h00;
  endproperty
  a_dly_off: assert property (p_dly_off) else $error("delay on");
  property p_no_mod; (!o_pll_enable && !o_mod_src_ext) [*4] |-> !o_mod_clk_en;
  endproperty
  a_no_mod: assert property (p_no_mod) else $error("pulse w/o pll");
endmodule // tcdt_checker

bind tcdt_top tcdt_checker u_chk (.*);
`default_nettype wire

// *** verification/tof_clock_delay_temp_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module tof_clock_delay_temp_regs_test;
  logic        i_sys_clk, i_sys_rst, i_hsel, i_hwrite, i_row_strobe;
  logic        i_ext_modulation_clock_in;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [7:0]  i_temp_tl, i_temp_tr, i_temp_bl, i_temp_br;
  logic        o_hreadyout, o_hresp, o_pll_enable, o_mod_src_ext;
  logic        o_mod_clk_en, o_led_mod;
  logic [9:0]  o_led_fine_delay;
  logic [5:0]  o_led_coarse_delay;
  wire         i_hready;
  int          n_fail = 0, total_checks = 0, cyc = 0;

  assign i_hready = o_hreadyout;
  tcdt_top dut (.*);

  initial begin
    i_sys_clk = 0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // hang guard, run needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // single word transfer; waits on hready, no fixed latency assumed
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_hsel <= 1'b1;
    i_haddr <= {22'h000000, idx, 2'h0};
    i_hwrite <= w;
    i_htrans <= 2'h2;
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= {24'h000000, d};
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task rc(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, e});
  endtask

  task t_reset;
    chk(o_pll_enable, 1); chk(o_mod_src_ext, 0);
    rc(8'h7D, 8'h04); rc(8'h80, 8'h3F); rc(8'h85, 8'h01);
    rc(8'h71, 8'h00); rc(8'h72, 8'h00); rc(8'h73, 8'h00);
  endtask

  task t_regs;
    wr(8'h7D, 8'hFF); wr(8'h80, 8'hFF); wr(8'h85, 8'hFF);
    rc(8'h7D, 8'h04); rc(8'h80, 8'h7F); rc(8'h85, 8'h1F);
    chk(o_mod_src_ext, 1);
    wr(8'h7D, 8'hFB); wr(8'h80, 8'h00);
    rc(8'h7D, 8'h00); rc(8'h80, 8'h3F);
    chk(o_pll_enable, 0); chk(o_mod_src_ext, 0);
    wr(8'h90, 8'h5A); rc(8'h90, 8'h00);
    wr(8'h60, 8'h5A); rc(8'h60, 8'h00);
    wr(8'h7D, 8'h04);
  endtask

  task t_delay;
    wr(8'h71, 8'h03); wr(8'h72, 8'h1F); wr(8'h73, 8'h31);
    rc(8'hAE, 8'h00); chk(o_led_fine_delay, 0); chk(o_led_coarse_delay, 0);
    wr(8'hAE, 8'hFF); rc(8'hAE, 8'h04);
    chk(o_led_fine_delay, 10'h31F); chk(o_led_coarse_delay, 6'h31);
    wr(8'h72, 8'h20); wr(8'h73, 8'h32); rc(8'h73, 8'h32);
    chk(o_led_fine_delay, 10'h31F); chk(o_led_coarse_delay, 6'h31);
    wr(8'h71, 8'h00); rc(8'h72, 8'h20); chk(o_led_fine_delay, 10'h020);
    wr(8'hAE, 8'h00); rc(8'hAE, 8'h00);
    chk(o_led_fine_delay, 0); chk(o_led_coarse_delay, 0);
  endtask

  function automatic logic [7:0] tv(int c, int k);
    return 8'h41 + 8'h10 * c[7:0] + k[7:0];
  endfunction

  task t_temp;
    int k, c;
    for (k = 0; k < 4; k++) begin
      if (k == 3) rc(8'h61, 8'h00);
      @(posedge i_sys_clk);
      i_temp_tl <= tv(0, k);
      i_temp_tr <= tv(1, k);
      i_temp_bl <= tv(2, k);
      i_temp_br <= tv(3, k);
      i_row_strobe <= 1'b1;
      @(posedge i_sys_clk);
      i_row_strobe <= 1'b0;
    end
    for (c = 0; c < 4; c++) begin
      rc(8'h60 + 2 * c[7:0], tv(c, 3));
      rc(8'h61 + 2 * c[7:0], 8'h4 * tv(c, 0) + 8'h06);
    end
  endtask

  // cycles up to the next pulse, or the next modulation edge
  task gap(input logic led, output int n);
    logic p;
    p = o_led_mod;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while ((led ? o_led_mod === p : o_mod_clk_en !== 1'b1) && n < 300);
  endtask

  task t_mod;
    int n, i, j, d;
    for (i = 0; i < 3; i++) begin
      d = (i == 0) ? 0 : (i == 1) ? 3 : 31;
      wr(8'h85, d[7:0]);
      repeat (3) gap(1'b0, n);
      chk(n, d + 1);
      repeat (3) gap(1'b1, n);
      chk(n, 2 * (d + 1));
    end
    wr(8'h7D, 8'h00);
    repeat (4) @(posedge i_sys_clk);
    n = 0;
    repeat (40) @(posedge i_sys_clk) if (o_mod_clk_en === 1'b1) n++;
    chk(n, 0);
    wr(8'h7D, 8'h04); wr(8'h80, 8'h40); rc(8'h80, 8'h7F);
    n = 0;
    for (j = 0; j < 46; j++) begin
      @(posedge i_sys_clk);
      i_ext_modulation_clock_in <= (j < 36) && (j % 6 < 3);
      if (o_mod_clk_en === 1'b1) n++;
    end
    chk(n, 6);
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_hsel = 1'b0;
    i_haddr = 32'h00000000;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h00000000;
    i_row_strobe = 1'b0;
    i_ext_modulation_clock_in = 1'b0;
    {i_temp_tl, i_temp_tr, i_temp_bl, i_temp_br} = 32'h00000000;
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_delay();
    t_temp();
    t_mod();
    report_and_stop();
  end
endmodule // tof_clock_delay_temp_regs_test
`default_nettype wire
